// ==== bench/chsmb_host.sv ====
`timescale 1ns/100ps
// behavioural smbus host: bus master that drives clock and data
module chsmb_host (
  // data line as seen on the wire
  input wire logic i_sda,
  // driven pins, data 1 means released to the pull-up
  output logic o_scl,
  output logic o_sda
);
  logic busy;

  // bus idle: clock stands high, data released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    busy = 1'b0;
  end

  // start or repeated start, data falls while clock high
  task automatic start();
    if (busy) begin
      o_scl = 1'b0;
      #40 o_sda = 1'b1;
      #40 o_scl = 1'b1;
    end
    #40 o_sda = 1'b0;
    #40 busy = 1'b1;
  endtask

  // stop, data rises while clock high, then clock stands still
  task automatic stop();
    o_scl = 1'b0;
    #40 o_sda = 1'b0;
    #40 o_scl = 1'b1;
    #40 o_sda = 1'b1;
    #40 busy = 1'b0;
  endtask

  // eight bits msb first then the acknowledge slot, data moves in low
  task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      o_scl = 1'b0;
      #40 o_sda = tx[i];
      #40 o_scl = 1'b1;
      #40 rx[i] = i_sda;
      #40;
    end
  endtask

  // write word: address, command, low byte, high byte, stop
  task automatic write_word(input logic [6:0] a, input logic [7:0] c,
                            input logic [15:0] d, output logic [3:0] nk);
    logic [8:0] r0, r1, r2, r3;
    start();
    bits({a, 2'b01}, r0);
    bits({c, 1'b1}, r1);
    bits({d[7:0], 1'b1}, r2);
    bits({d[15:8], 1'b1}, r3);
    stop();
    nk = {r0[0], r1[0], r2[0], r3[0]};
  endtask

  // read word: command phase, repeated start, two bytes back
  task automatic read_word(input logic [6:0] a, input logic [7:0] c,
                           output logic [15:0] d, output logic [2:0] nk);
    logic [8:0] r0, r1, r2, lo, hi;
    start();
    bits({a, 2'b01}, r0);
    bits({c, 1'b1}, r1);
    start();
    bits({a, 2'b11}, r2);
    bits({8'hFF, 1'b0}, lo);
    bits({8'hFF, 1'b1}, hi);
    stop();
    d = {hi[8:1], lo[8:1]};
    nk = {r0[0], r1[0], r2[0]};
  endtask
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
// self-checking bench for the charger smbus control block
module testbench import chsmb_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda_h, sda_oe_n, sda_out;
  chsmb_ana_type ana = '0;
  logic [15:0] thr = '0;
  chsmb_sw_type sw;
  chsmb_gate_type gate;
  logic [1:0] depl;
  logic [15:0] expq[$];
  logic [15:0] rd;
  logic [15:0] wd [NREG];
  logic [3:0] nk;
  logic [2:0] rk;
  int err_count = 0;
  int comparisons = 0;
  event rd_ev;
  logic [5:0] stp [9] = '{6'h22, 6'h01, 6'h10, 6'h22, 6'h01, 6'h08,
                          6'h22, 6'h00, 6'h05};
  // open-drain wire with pull-up
  wire sda = sda_h & ((sda_oe_n !== 1'b0) | sda_out);

  always #4 clk = ~clk;

  // identity values are arbitrary
  chsmb_ctrl #(.P_BATP_CYC(100), .P_MAKER_ID(16'h00C3),
    .P_PART_ID(16'h003C)) chsmb_ctrl_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda_in(sda),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_ana(ana),
    .i_throttle_flags(thr), .o_sw(sw), .o_gate(gate),
    .o_depletion_threshold_select(depl));
  chsmb_host chsmb_host_i (.i_sda(sda), .o_scl(scl), .o_sda(sda_h));

  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // read a word, note the expected value for the monitor
  task automatic rd_exp(input logic [7:0] c, input logic [15:0] e);
    expq.push_back(e);
    chsmb_host_i.read_word(SLAVE_ADDR, c, rd, rk);
    check("read ack", 16'h0000, {13'h0000, rk});
    -> rd_ev;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] c,
                    input logic [15:0] d, input logic [3:0] e);
    chsmb_host_i.write_word(a, c, d, nk);
    check("write ack", {12'h000, e}, {12'h000, nk});
  endtask

  task automatic wait_sw(input chsmb_sw_type e, input int lim);
    int n;
    n = 0;
    while (sw !== e && n < lim) begin
      @(negedge clk);
      n++;
    end
    check("switches", {13'h0000, e}, {13'h0000, sw});
    // only a real timeout ends the run early
    if (sw !== e && lim > 1)
      finish_test();
  endtask

  // one converter phase with comparator levels, then gate check
  task automatic ph(input logic [3:0] f, input chsmb_gate_type e);
    @(negedge clk);
    ana.ramp_below_error_amp = f[3];
    ana.undercurrent_detector = f[2];
    ana.ll_below_125 = f[1] & ~ana.boost_mode;
    ana.ll_below_250 = f[1] & ana.boost_mode;
    ana.ll_above_250 = f[0] & ~ana.boost_mode;
    ana.ll_above_500 = f[0] & ana.boost_mode;
    repeat (16) @(negedge clk);
    check("gates", {14'h0000, e}, {14'h0000, gate});
  endtask

  // monitor: read results against oldest note, gate overlap
  always @(rd_ev) check("read data", expq.pop_front(), rd);
  always @(negedge clk)
    if (gate === 2'b11) check("overlap", 16'h0000, 16'h0003);

  initial begin
    void'($urandom(61));
    thr = 16'($urandom);
    ana.adapter_present = 1'b1;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    check("depl sel", 16'h0003, {14'h0000, depl});
    wr(SLAVE_ADDR, CMD_ICHG, 16'h1234, 4'hF);
    ana.supply_ok = 1'b1;
    repeat (8) @(negedge clk);
    foreach (CMD_TAB[i]) rd_exp(CMD_TAB[i], RST_TAB[i]);
    wr(SLAVE_ADDR, CMD_MAKER, 16'hFFFF, 4'h0);
    wr(SLAVE_ADDR, CMD_PART, 16'hFFFF, 4'h0);
    wr(SLAVE_ADDR, CMD_THR_ST, 16'hFFFF, 4'h0);
    rd_exp(CMD_MAKER, 16'h00C3);
    rd_exp(CMD_PART, 16'h003C);
    rd_exp(CMD_THR_ST, thr);
    rd_exp(8'h20, 16'h0000);
    for (int b = 0; b < 7; b++)
      wr(SLAVE_ADDR ^ 7'(1 << b), CMD_ICHG, 16'hBEEF, 4'hF);
    rd_exp(CMD_ICHG, 16'h0000);
    for (int i = 1; i < NREG; i++) begin
      wd[i] = 16'($urandom);
      wr(SLAVE_ADDR, CMD_TAB[i], wd[i], 4'h0);
    end
    for (int i = 1; i < NREG; i++) rd_exp(CMD_TAB[i], wd[i]);
    check("depl sel", {14'h0, wd[IDX_OPT_B][15:14]}, {14'h0, depl});
    // learn cycle: entry, depletion exit, refusal when depleted
    wait_sw(3'b110, 20);
    wr(SLAVE_ADDR, CMD_OPT_A, 16'hE128, 4'h0);
    wait_sw(3'b001, 20);
    ana.batt_below_depl = 1'b1;
    wait_sw(3'b110, 2600);
    rd_exp(CMD_OPT_A, 16'hE108);
    wr(SLAVE_ADDR, CMD_OPT_A, 16'hE128, 4'h0);
    repeat (10) @(negedge clk);
    wait_sw(3'b110, 1);
    rd_exp(CMD_OPT_A, 16'hE108);
    // battery removal and adapter loss end the cycle
    ana.batt_below_depl = 1'b0;
    wr(SLAVE_ADDR, CMD_OPT_A, 16'hE128, 4'h0);
    wait_sw(3'b001, 20);
    ana.battery_present_input = 1'b1;
    wait_sw(3'b110, 20);
    rd_exp(CMD_OPT_A, 16'hE108);
    ana.battery_present_input = 1'b0;
    wr(SLAVE_ADDR, CMD_OPT_A, 16'hE128, 4'h0);
    wait_sw(3'b001, 20);
    ana.adapter_present = 1'b0;
    repeat (20) @(negedge clk);
    wait_sw(3'b001, 1);
    rd_exp(CMD_OPT_A, 16'hE108);
    ana.adapter_present = 1'b1;
    wait_sw(3'b110, 20);
    // gate drive in charge then boost, gates swap roles
    for (int m = 0; m < 2; m++) begin
      ana.boost_mode = m[0];
      foreach (stp[k])
        ph(stp[k][5:2],
          m ? {stp[k][0], stp[k][1]} : stp[k][1:0]);
    end
    // charge block bit stops both gates in charge mode
    ana.boost_mode = 1'b0;
    wr(SLAVE_ADDR, CMD_OPT_A, 16'hE109, 4'h0);
    rd_exp(CMD_OPT_A, 16'hE109);
    ph(4'h8, 2'b00);
    ph(4'h0, 2'b00);
    finish_test();
  end
endmodule

// ==== hdl/chsmb_ctrl.sv ====
`timescale 1ns/100ps
// charger smbus control: slave, register map, learn cycle, gate drive

// Functional notes
// - learn set: adapter switches off, battery on
// - learn ends when battery below depletion threshold
// - learn enable bit clears itself on exit
// - adapter loss ends learn; host re-enables later
// - battery removal ends learn, adapter on fast
// - dead time between high and low switch
// - undercurrent blocks low or high switch per cycle
// - charge light load hysteresis 125/250 mA
// - boost light load hysteresis 250/500 mA
// - answer only at slave address 0x09
// - device never starts a bus transfer
// - bus idle until supply above lockout
// - start and stop are sda edges, scl high
// - msb first bytes, ninth clock acknowledge
// - write word and read word framing
// - written word takes effect at stop
// - two fixed read-only identity registers
// - learn refused when battery already depleted
module chsmb_ctrl import chsmb_pkg::*; #(
  parameter int P_BATP_CYC = BATP_CYC,
  parameter logic [15:0] P_MAKER_ID = 16'h00A5, // arbitrary value
  parameter logic [15:0] P_PART_ID = 16'h005A // arbitrary value
) (
  // clocks and reset
  input logic i_clk,
  input logic i_rst_n,
  input logic i_scl,
  // bus data pin
  input logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  // analog comparators and status
  input chsmb_ana_type i_ana,
  input logic [15:0] i_throttle_flags,
  // power path and converter gates
  output chsmb_sw_type o_sw,
  output chsmb_gate_type o_gate,
  output logic [1:0] o_depletion_threshold_select
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  chsmb_ana_type ana_m_reg;
  chsmb_ana_type ana_s_reg;
  logic [15:0] thr_m_reg;
  logic [15:0] thr_s_reg;
  logic scl_m_reg;
  logic scl_s_reg;
  logic scl_d_reg;
  logic sda_m_reg;
  logic sda_s_reg;
  logic sda_d_reg;
  logic [7:0] rx_shift_reg;
  chsmb_bus_type state_reg;
  chsmb_bus_type nxt_reg;
  logic [3:0] bit_cnt_reg;
  logic ack_reg;
  logic sda_drv_reg;
  logic wr_ok_reg;
  logic [7:0] cmd_reg;
  logic [7:0] wr_lo_reg;
  logic [7:0] wr_hi_reg;
  logic [15:0] tx_reg;
  logic [15:0] reg_file_reg [NREG];
  logic learn_reg;
  logic [11:0] depl_cnt_reg;
  chsmb_sw_type sw_reg;
  logic uc_block_reg;
  logic llc_reg;
  logic llb_reg;
  logic pwm_d_reg;
  chsmb_gate_type gate_reg;
  logic [2:0] dead_cnt_reg;
  logic [15:0] batp_cnt_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic sup_ok;
  logic commit;
  logic [3:0] cmd_idx;
  logic [15:0] rd_word;
  logic [7:0] tx_byte;
  logic is_tx;
  logic depl_done;
  logic learn_exit;
  logic boost;
  logic run;
  logic hs_want;
  logic ls_want;
  logic both_off;

  // map a command code to its register index, NREG when none
  function automatic logic [3:0] cmd_index(input logic [7:0] cmd);
    cmd_index = 4'(NREG);
    for (int k = 0; k < NREG; k++) begin
      if (CMD_TAB[k] == cmd) begin
        cmd_index = 4'(k);
      end
    end
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // two flops for every pin; a third copy only for edge detection
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ana_m_reg <= '0;
      ana_s_reg <= '0;
      thr_m_reg <= 16'h0000;
      thr_s_reg <= 16'h0000;
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      ana_m_reg <= i_ana;
      ana_s_reg <= ana_m_reg;
      thr_m_reg <= i_throttle_flags;
      thr_s_reg <= thr_m_reg;
      scl_m_reg <= i_scl;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= i_sda_in;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
    end
  end

  // bus events seen in the system clock domain
  assign sup_ok = ana_s_reg.supply_ok;
  assign scl_rise = scl_s_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg & scl_d_reg;
  assign start_evt = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign stop_evt = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

  // ------------------------------------------------------------
  // link clock domain
  // ------------------------------------------------------------
  // bits enter msb first on rising scl; read only after the
  // synchronised eighth rise, when the byte stands still
  always_ff @(posedge i_scl) begin
    rx_shift_reg <= {rx_shift_reg[6:0], i_sda_in};
  end

  // ------------------------------------------------------------
  // bus engine
  // ------------------------------------------------------------
  assign is_tx = (state_reg == BUS_RLO) || (state_reg == BUS_RHI);
  assign tx_byte = (state_reg == BUS_RLO) ? tx_reg[7:0] : tx_reg[15:8];

  // slave only: leaves idle on a master start, never on its own
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !sup_ok) begin
      state_reg <= BUS_IDLE;
      nxt_reg <= BUS_IDLE;
      bit_cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      wr_ok_reg <= 1'b0;
      cmd_reg <= 8'h00;
      wr_lo_reg <= 8'h00;
      wr_hi_reg <= 8'h00;
      tx_reg <= 16'h0000;
    end else if (start_evt) begin
      state_reg <= BUS_ADDR;
      bit_cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      wr_ok_reg <= 1'b0;
    end else if (stop_evt) begin
      state_reg <= BUS_IDLE;
      sda_drv_reg <= 1'b0;
      wr_ok_reg <= 1'b0;
    end else if (state_reg != BUS_IDLE) begin
      if (scl_rise && bit_cnt_reg == 4'h8) begin
        // ninth clock: acknowledge slot ends
        bit_cnt_reg <= 4'h0;
        ack_reg <= 1'b0;
        if (is_tx && sda_s_reg) begin
          state_reg <= BUS_SKIP;
        end else begin
          state_reg <= nxt_reg;
        end
      end else if (scl_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == 4'h7) begin
          // eighth bit in: decide on the byte
          unique case (state_reg)
            BUS_ADDR: begin
              if (rx_shift_reg[7:1] == SLAVE_ADDR) begin
                ack_reg <= 1'b1;
                if (rx_shift_reg[0]) begin
                  nxt_reg <= BUS_RLO;
                  tx_reg <= rd_word;
                end else begin
                  nxt_reg <= BUS_CMD;
                end
              end else begin
                ack_reg <= 1'b0;
                nxt_reg <= BUS_SKIP;
              end
            end
            BUS_CMD: begin
              cmd_reg <= rx_shift_reg;
              ack_reg <= 1'b1;
              nxt_reg <= BUS_DLO;
            end
            BUS_DLO: begin
              wr_lo_reg <= rx_shift_reg;
              ack_reg <= 1'b1;
              nxt_reg <= BUS_DHI;
            end
            BUS_DHI: begin
              wr_hi_reg <= rx_shift_reg;
              ack_reg <= 1'b1;
              wr_ok_reg <= 1'b1;
              nxt_reg <= BUS_SKIP;
            end
            BUS_RLO: begin
              ack_reg <= 1'b0;
              nxt_reg <= BUS_RHI;
            end
            BUS_RHI, BUS_SKIP, BUS_IDLE: begin
              ack_reg <= 1'b0;
              nxt_reg <= BUS_SKIP;
            end
          endcase
        end
      end
      // sda changes only after scl has fallen
      if (scl_fall) begin
        if (bit_cnt_reg == 4'h8) begin
          sda_drv_reg <= ack_reg;
        end else if (is_tx) begin
          sda_drv_reg <= ~tx_byte[3'(4'h7 - bit_cnt_reg)];
        end else begin
          sda_drv_reg <= 1'b0;
        end
      end
    end
  end

  // open drain: enable low only while pulling the line low
  assign o_sda_out = 1'b0;
  assign o_sda_oe_n = ~sda_drv_reg;

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  assign cmd_idx = cmd_index(cmd_reg);
  assign commit = stop_evt && wr_ok_reg && (state_reg != BUS_IDLE);

  // read word for the current command
  always_comb begin
    rd_word = 16'h0000;
    if (cmd_reg == CMD_MAKER) begin
      rd_word = P_MAKER_ID;
    end else if (cmd_reg == CMD_PART) begin
      rd_word = P_PART_ID;
    end else if (cmd_reg == CMD_THR_ST) begin
      rd_word = thr_s_reg;
    end else if (cmd_idx < 4'(NREG)) begin
      rd_word = reg_file_reg[cmd_idx];
      if (cmd_idx == 4'(IDX_OPT_A)) begin
        rd_word[LEARN_BIT] = learn_reg;
      end
    end
  end

  // one word per writable command; read-only codes have no slot
  for (genvar g = 0; g < NREG; g++) begin : g_regs
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        reg_file_reg[g] <= RST_TAB[g];
      end else if (commit && cmd_idx == 4'(g)) begin
        reg_file_reg[g] <= {wr_hi_reg, wr_lo_reg};
      end
    end
  end

  assign o_depletion_threshold_select =
    reg_file_reg[IDX_OPT_B][DEPL_MSB:DEPL_LSB];

  // ------------------------------------------------------------
  // learn cycle
  // ------------------------------------------------------------
  // depletion is filtered so battery removal always wins the race
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !learn_reg || !ana_s_reg.batt_below_depl) begin
      depl_cnt_reg <= 12'h000;
    end else if (!depl_done) begin
      depl_cnt_reg <= depl_cnt_reg + 12'h001;
    end
  end

  assign depl_done = learn_reg && ana_s_reg.batt_below_depl &&
    (depl_cnt_reg == DEPL_MAX);
  assign learn_exit = ana_s_reg.battery_present_input |
    ~ana_s_reg.adapter_present | depl_done;

  // exit clears the bit; host write applied at stop otherwise
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      learn_reg <= 1'b0;
    end else if (learn_reg && learn_exit) begin
      learn_reg <= 1'b0;
    end else if (commit && cmd_idx == 4'(IDX_OPT_A)) begin
      learn_reg <= wr_lo_reg[LEARN_BIT] &&
        !ana_s_reg.batt_below_depl;
    end
  end

  // power path switches
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sw_reg <= '0;
    end else begin
      sw_reg.adapter_input_switch <=
        ana_s_reg.adapter_present && !learn_reg;
      sw_reg.reverse_blocking_switch <=
        ana_s_reg.adapter_present && !learn_reg;
      sw_reg.battery_path_switch <=
        learn_reg || !ana_s_reg.adapter_present;
    end
  end

  assign o_sw = sw_reg;

  // ------------------------------------------------------------
  // converter gate logic
  // ------------------------------------------------------------
  // undercurrent block holds until the next on phase starts;
  // light load flags follow their two-level hysteresis
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pwm_d_reg <= 1'b0;
      uc_block_reg <= 1'b0;
      llc_reg <= 1'b0;
      llb_reg <= 1'b0;
    end else begin
      pwm_d_reg <= ana_s_reg.ramp_below_error_amp;
      if (ana_s_reg.undercurrent_detector) begin
        uc_block_reg <= 1'b1;
      end else if (ana_s_reg.ramp_below_error_amp && !pwm_d_reg) begin
        uc_block_reg <= 1'b0;
      end
      if (ana_s_reg.ll_below_125) begin
        llc_reg <= 1'b1;
      end else if (ana_s_reg.ll_above_250) begin
        llc_reg <= 1'b0;
      end
      if (ana_s_reg.ll_below_250) begin
        llb_reg <= 1'b1;
      end else if (ana_s_reg.ll_above_500) begin
        llb_reg <= 1'b0;
      end
    end
  end

  // wanted switch per phase; never both at once
  assign boost = ana_s_reg.boost_mode;
  assign run = sup_ok &&
    (boost || !reg_file_reg[IDX_OPT_A][INHIBIT_BIT]);
  assign hs_want = run && (boost ?
    (!ana_s_reg.ramp_below_error_amp && !uc_block_reg && !llb_reg) :
    ana_s_reg.ramp_below_error_amp);
  assign ls_want = run && (boost ? ana_s_reg.ramp_below_error_amp :
    (!ana_s_reg.ramp_below_error_amp && !uc_block_reg && !llc_reg));
  assign both_off = !gate_reg.high_side_switch &&
    !gate_reg.low_side_switch;

  // break before make with a counted dead time
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gate_reg <= '0;
      dead_cnt_reg <= 3'h0;
    end else begin
      if (!both_off) begin
        dead_cnt_reg <= 3'h0;
      end else if (dead_cnt_reg != DEAD_MAX) begin
        dead_cnt_reg <= dead_cnt_reg + 3'h1;
      end
      gate_reg.high_side_switch <= hs_want && (gate_reg.high_side_switch
        || (both_off && dead_cnt_reg == DEAD_MAX));
      gate_reg.low_side_switch <= ls_want && (gate_reg.low_side_switch
        || (both_off && dead_cnt_reg == DEAD_MAX));
    end
  end

  assign o_gate = gate_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // time the adapter switch stays off with battery gone
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !ana_s_reg.battery_present_input ||
        !ana_s_reg.adapter_present || sw_reg.adapter_input_switch) begin
      batp_cnt_reg <= 16'h0000;
    end else if (batp_cnt_reg != 16'hFFFF) begin
      batp_cnt_reg <= batp_cnt_reg + 16'h0001;
    end
  end

  sequence s_batp_gone;
    learn_reg && ana_s_reg.battery_present_input;
  endsequence

  sequence s_adp_back;
    !learn_reg ##1
      (sw_reg.adapter_input_switch || !$past(ana_s_reg.adapter_present));
  endsequence

  learn_path_a: assert property (learn_reg |=>
    !sw_reg.adapter_input_switch && sw_reg.battery_path_switch)
    else $error("learn active but adapter path on");
  depl_exit_a: assert property (depl_done |=> !learn_reg)
    else $error("depletion did not end learn");
  self_clear_a: assert property ($fell(learn_reg) |->
    $past(learn_exit) || $past(commit))
    else $error("learn bit cleared without cause");
  adp_loss_a: assert property (
    learn_reg && !ana_s_reg.adapter_present |=>
    !learn_reg ##1 sw_reg.battery_path_switch)
    else $error("adapter loss handling wrong");
  batp_exit_a: assert property (s_batp_gone |=> s_adp_back)
    else $error("battery removal did not restore adapter");
  batp_time_a: assert property (batp_cnt_reg < 16'(P_BATP_CYC))
    else $error("adapter switch restore too slow");
  no_overlap_a: assert property (
    $fell(gate_reg.high_side_switch) |-> !gate_reg.low_side_switch [*5])
    else $error("dead time too short");
  uc_block_a: assert property (
    ana_s_reg.undercurrent_detector && !boost ##1 !boost |=>
    !gate_reg.low_side_switch)
    else $error("undercurrent did not block low side");
  llc_hold_a: assert property ($fell(llc_reg) |->
    $past(ana_s_reg.ll_above_250) && !$past(ana_s_reg.ll_below_125))
    else $error("charge light load released early");
  llb_hold_a: assert property (llb_reg && boost |=>
    !gate_reg.high_side_switch)
    else $error("boost light load did not hold high side");
  addr_miss_a: assert property (
    state_reg == BUS_ADDR && scl_rise && bit_cnt_reg == 4'h7 &&
    rx_shift_reg[7:1] != SLAVE_ADDR |=> !ack_reg && nxt_reg == BUS_SKIP)
    else $error("foreign address acknowledged");
  lockout_idle_a: assert property (!sup_ok |=>
    o_sda_oe_n && state_reg == BUS_IDLE)
    else $error("bus active below lockout");
  commit_stop_a: assert property (
    $changed(reg_file_reg[1]) |-> $past(stop_evt))
    else $error("register changed outside stop");

endmodule

// ==== hdl/chsmb_pkg.sv ====
// charger smbus control: shared constants and types
package chsmb_pkg;

  // --------------------------------------------------------------
  // bus addressing and command codes
  // --------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h09;
  localparam int NREG = 11;
  localparam logic [7:0] CMD_OPT_A = 8'h12;
  localparam logic [7:0] CMD_ICHG = 8'h14;
  localparam logic [7:0] CMD_VCHG = 8'h15;
  localparam logic [7:0] CMD_OPT_D = 8'h37;
  localparam logic [7:0] CMD_OPT_C = 8'h38;
  localparam logic [7:0] CMD_IDCHG = 8'h39;
  localparam logic [7:0] CMD_THR_ST = 8'h3A;
  localparam logic [7:0] CMD_OPT_B = 8'h3B;
  localparam logic [7:0] CMD_THR_A = 8'h3C;
  localparam logic [7:0] CMD_THR_B = 8'h3D;
  localparam logic [7:0] CMD_VMIN = 8'h3E;
  localparam logic [7:0] CMD_IIN = 8'h3F;
  localparam logic [7:0] CMD_MAKER = 8'hFE;
  localparam logic [7:0] CMD_PART = 8'hFF;

  // --------------------------------------------------------------
  // writable register file: command and reset value per index
  // --------------------------------------------------------------
  localparam logic [7:0] CMD_TAB [NREG] = '{
    CMD_OPT_A, CMD_ICHG, CMD_VCHG, CMD_OPT_D, CMD_OPT_C, CMD_IDCHG,
    CMD_OPT_B, CMD_THR_A, CMD_THR_B, CMD_VMIN, CMD_IIN};
  localparam logic [15:0] RST_TAB [NREG] = '{
    16'hE108, 16'h0000, 16'h0000, 16'h1A40, 16'h0384, 16'h1800,
    16'hC220, 16'h4A54, 16'h8120, 16'h2300, 16'h1000};
  localparam int IDX_OPT_A = 0;
  localparam int IDX_OPT_B = 6;
  localparam int LEARN_BIT = 5;
  localparam int INHIBIT_BIT = 0;
  localparam int DEPL_MSB = 15;
  localparam int DEPL_LSB = 14;

  // --------------------------------------------------------------
  // timing, clock at 8 ns
  // --------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int DEAD_NS = 40;
  localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] DEAD_MAX = 3'(DEAD_CYC);
  localparam int DEPL_FILT_NS = 20000;
  localparam int DEPL_CYC = DEPL_FILT_NS / CLK_NS;
  localparam logic [11:0] DEPL_MAX = 12'(DEPL_CYC - 1);
  localparam int BATP_MAX_NS = 100000;
  localparam int BATP_CYC = BATP_MAX_NS / CLK_NS;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h0,
    BUS_ADDR = 3'h1,
    BUS_CMD = 3'h3,
    BUS_DLO = 3'h2,
    BUS_DHI = 3'h6,
    BUS_RLO = 3'h7,
    BUS_RHI = 3'h5,
    BUS_SKIP = 3'h4
  } chsmb_bus_type;

  typedef struct packed {
    logic supply_ok;
    logic adapter_present;
    logic battery_present_input;
    logic batt_below_depl;
    logic ramp_below_error_amp;
    logic undercurrent_detector;
    logic ll_below_125;
    logic ll_above_250;
    logic ll_below_250;
    logic ll_above_500;
    logic boost_mode;
  } chsmb_ana_type;

  typedef struct packed {
    logic adapter_input_switch;
    logic reverse_blocking_switch;
    logic battery_path_switch;
  } chsmb_sw_type;

  typedef struct packed {
    logic high_side_switch;
    logic low_side_switch;
  } chsmb_gate_type;

endpackage
